// [verilog/msxo_exec.sv]
// execution unit for nibble swap, zero skips, table reads and xor
`timescale 1ns/1ps
module msxo_exec
    import msxo_pkg::*;
#(
    parameter int PAW = PC_W
) (
    // clock and reset
    input  wire logic                  MCLK,
    input  wire logic                  RST,
    // decoded instruction
    input  wire logic                  OP_VALID,
    input  wire logic [OP_W-1:0]       OP_CODE,
    input  wire logic [DATA_W-1:0]     MEM_RDATA,
    input  wire logic [DATA_W-1:0]     IMM_DATA,
    input  wire logic [BIT_SEL_W-1:0]  BIT_SEL,
    input  wire logic [PAW-1:0]        PC_NOW,
    // table pointers
    input  wire logic [DATA_W-1:0]     TABLE_POINTER_LOWER,
    input  wire logic [PAW-DATA_W-1:0] TABLE_POINTER_UPPER,
    // program memory load port
    input  wire logic                  PROG_WR_EN,
    input  wire logic [PAW-1:0]        PROG_WR_ADDR,
    input  wire logic [PROG_W-1:0]     PROG_WR_DATA,
    // status flags in
    input  wire logic [FLAGS_W-1:0]    FLAGS_IN,
    // results
    output logic                       MEM_WE,
    output logic      [DATA_W-1:0]     MEM_WDATA,
    output logic      [DATA_W-1:0]     ACC,
    output logic      [DATA_W-1:0]     TABLE_UPPER_BYTE_REG,
    output logic                       FLAGS_WE,
    output logic      [FLAGS_W-1:0]    FLAGS_OUT,
    output logic                       DUMMY_INSERT,
    output logic                       BUSY
);
    msxo_state_t           state_ff, nxt_state;
    logic [DATA_W-1:0]     acc_ff, nxt_acc;
    logic [DATA_W-1:0]     tub_ff, nxt_tub;
    logic                  busy_ff, nxt_busy;
    logic                  mem_we_ff, nxt_mem_we;
    logic [DATA_W-1:0]     mem_wdata_ff, nxt_mem_wdata;
    logic                  flags_we_ff, nxt_flags_we;
    logic [FLAGS_W-1:0]    flags_ff, nxt_flags;
    logic                  dummy_ff, nxt_dummy;
    logic [PAW-1:0]        tbl_addr;
    logic [PROG_W-1:0]     rom_word;
    logic [DATA_W-1:0]     swapped;
    logic [DATA_W-1:0]     xor_m;
    logic [DATA_W-1:0]     xor_i;
    logic                  take;

    assign swapped = {MEM_RDATA[NIB_W-1:0], MEM_RDATA[DATA_W-1:NIB_W]};
    assign xor_m   = acc_ff ^ MEM_RDATA;
    assign xor_i   = acc_ff ^ IMM_DATA;
    assign take    = OP_VALID && (state_ff == ST_IDLE);

    // table address per page mode
    always_comb begin
        case (msxo_op_t'(OP_CODE))
            OP_TBL_GIVEN:   tbl_addr = {TABLE_POINTER_UPPER, TABLE_POINTER_LOWER};
            OP_TBL_CURRENT: tbl_addr = {PC_NOW[PAW-1:DATA_W], TABLE_POINTER_LOWER};
            OP_TBL_FINAL:   tbl_addr = {{(PAW-DATA_W){1'b1}}, TABLE_POINTER_LOWER};
            default:        tbl_addr = {{(PAW-DATA_W){1'b0}}, TABLE_POINTER_LOWER};
        endcase
    end

    msxo_prog_rom #(.AW(PAW), .DW(PROG_W)) u_rom (
        .clk     (MCLK),
        .wr_en   (PROG_WR_EN),
        .wr_addr (PROG_WR_ADDR),
        .wr_data (PROG_WR_DATA),
        .rd_addr (tbl_addr),
        .rd_data (rom_word)
    );

    always_comb begin
        nxt_state     = ST_IDLE;
        nxt_acc       = acc_ff;
        nxt_tub       = tub_ff;
        nxt_mem_we    = 1'b0;
        nxt_mem_wdata = mem_wdata_ff;
        nxt_flags_we  = 1'b0;
        nxt_flags     = FLAGS_IN;
        nxt_dummy     = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (take) begin
                    case (msxo_op_t'(OP_CODE))
                        OP_NIB_SWAP: begin
                            nxt_mem_we    = 1'b1;
                            nxt_mem_wdata = swapped;
                        end
                        OP_NIB_TO_ACC: nxt_acc = swapped;
                        OP_SKIP_NULL: begin
                            if (MEM_RDATA == ZERO_B) begin
                                nxt_state = ST_DUMMY;
                            end
                        end
                        OP_COPY_SKIP: begin
                            nxt_acc = MEM_RDATA;
                            if (MEM_RDATA == ZERO_B) begin
                                nxt_state = ST_DUMMY;
                            end
                        end
                        OP_SKIP_BIT_CLR: begin
                            if (!MEM_RDATA[BIT_SEL]) begin
                                nxt_state = ST_DUMMY;
                            end
                        end
                        OP_TBL_GIVEN, OP_TBL_CURRENT, OP_TBL_FINAL: nxt_state = ST_TBL;
                        OP_XOR_ACC: begin
                            nxt_acc              = xor_m;
                            nxt_flags_we         = 1'b1;
                            nxt_flags[ZF_BIT]    = (xor_m == ZERO_B);
                        end
                        OP_XOR_MEM: begin
                            nxt_mem_we           = 1'b1;
                            nxt_mem_wdata        = xor_m;
                            nxt_flags_we         = 1'b1;
                            nxt_flags[ZF_BIT]    = (xor_m == ZERO_B);
                        end
                        OP_XOR_IMM: begin
                            nxt_acc              = xor_i;
                            nxt_flags_we         = 1'b1;
                            nxt_flags[ZF_BIT]    = (xor_i == ZERO_B);
                        end
                        default: nxt_state = ST_IDLE;
                    endcase
                end
            end
            ST_TBL: begin
                // rom word arrives one cycle after the address
                nxt_mem_we    = 1'b1;
                nxt_mem_wdata = rom_word[DATA_W-1:0];
                nxt_tub       = rom_word[PROG_W-1:DATA_W];
            end
            ST_DUMMY: nxt_dummy = 1'b1;
            default: nxt_state = ST_IDLE;
        endcase
        // busy mirrors the extra cycle so the decoder holds the next op
        nxt_busy = (nxt_state != ST_IDLE);
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            state_ff     <= ST_IDLE;
            acc_ff       <= ACC_RST;
            tub_ff       <= TUB_RST;
            busy_ff      <= 1'b0;
            mem_we_ff    <= 1'b0;
            mem_wdata_ff <= ZERO_B;
            flags_we_ff  <= 1'b0;
            flags_ff     <= '0;
            dummy_ff     <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            acc_ff       <= nxt_acc;
            tub_ff       <= nxt_tub;
            busy_ff      <= nxt_busy;
            mem_we_ff    <= nxt_mem_we;
            mem_wdata_ff <= nxt_mem_wdata;
            flags_we_ff  <= nxt_flags_we;
            flags_ff     <= nxt_flags;
            dummy_ff     <= nxt_dummy;
        end
    end

    // outputs straight from flops
    assign MEM_WE               = mem_we_ff;
    assign MEM_WDATA            = mem_wdata_ff;
    assign ACC                  = acc_ff;
    assign TABLE_UPPER_BYTE_REG = tub_ff;
    assign FLAGS_WE             = flags_we_ff;
    assign FLAGS_OUT            = flags_ff;
    assign DUMMY_INSERT         = dummy_ff;
    assign BUSY                 = busy_ff;

    sequence s_zero_skip;
        take && msxo_op_t'(OP_CODE) == OP_SKIP_NULL && MEM_RDATA == ZERO_B;
    endsequence
    sequence s_dummy_slot;
        !DUMMY_INSERT ##1 DUMMY_INSERT ##1 !DUMMY_INSERT;
    endsequence

    a_swap_writeback: assert property (@(posedge MCLK) disable iff (RST)
        take && msxo_op_t'(OP_CODE) == OP_NIB_SWAP |=> MEM_WE && !FLAGS_WE
            && MEM_WDATA == {$past(MEM_RDATA[3:0]), $past(MEM_RDATA[7:4])})
        else $error("nibble swap writeback wrong");
    a_swap_acc: assert property (@(posedge MCLK) disable iff (RST)
        take && msxo_op_t'(OP_CODE) == OP_NIB_TO_ACC |=> !MEM_WE && !FLAGS_WE
            && ACC == {$past(MEM_RDATA[3:0]), $past(MEM_RDATA[7:4])})
        else $error("swap to acc wrong");
    a_zero_skip: assert property (@(posedge MCLK) disable iff (RST)
        s_zero_skip |=> s_dummy_slot)
        else $error("zero byte skip missing");
    a_no_skip: assert property (@(posedge MCLK) disable iff (RST)
        take && msxo_op_t'(OP_CODE) == OP_SKIP_NULL && MEM_RDATA != ZERO_B
            |-> ##2 !DUMMY_INSERT)
        else $error("skip taken on nonzero byte");
    a_copy_skip: assert property (@(posedge MCLK) disable iff (RST)
        take && msxo_op_t'(OP_CODE) == OP_COPY_SKIP |=> ACC == $past(MEM_RDATA)
            && !FLAGS_WE ##1 DUMMY_INSERT == ($past(ACC) == ZERO_B))
        else $error("copy and skip wrong");
    a_bit_skip: assert property (@(posedge MCLK) disable iff (RST)
        take && msxo_op_t'(OP_CODE) == OP_SKIP_BIT_CLR && !MEM_RDATA[BIT_SEL]
            |-> ##2 DUMMY_INSERT)
        else $error("bit clear skip missing");
    a_table_read: assert property (@(posedge MCLK) disable iff (RST)
        take && msxo_op_t'(OP_CODE) inside {OP_TBL_GIVEN, OP_TBL_CURRENT, OP_TBL_FINAL}
            |=> !MEM_WE ##1 MEM_WE && !FLAGS_WE)
        else $error("table read write missing");
    a_xor_zero: assert property (@(posedge MCLK) disable iff (RST)
        FLAGS_WE |-> FLAGS_OUT[ZF_BIT] == (MEM_WE ? (MEM_WDATA == ZERO_B) : (ACC == ZERO_B)))
        else $error("zero flag mismatch");
    a_xor_acc: assert property (@(posedge MCLK) disable iff (RST)
        take && msxo_op_t'(OP_CODE) == OP_XOR_ACC
            |=> ACC == ($past(ACC) ^ $past(MEM_RDATA)) && FLAGS_WE && !MEM_WE)
        else $error("xor to acc wrong");
    a_xor_mem: assert property (@(posedge MCLK) disable iff (RST)
        take && msxo_op_t'(OP_CODE) == OP_XOR_MEM
            |=> MEM_WE && MEM_WDATA == ($past(ACC) ^ $past(MEM_RDATA)) && ACC == $past(ACC))
        else $error("xor to memory wrong");
    a_xor_imm: assert property (@(posedge MCLK) disable iff (RST)
        take && msxo_op_t'(OP_CODE) == OP_XOR_IMM
            |=> ACC == ($past(ACC) ^ $past(IMM_DATA)) && FLAGS_WE)
        else $error("xor immediate wrong");
endmodule

// [verilog/msxo_pkg.sv]
// shared constants for the swap, skip, table read and xor execution block
package msxo_pkg;
    localparam int DATA_W     = 8;
    localparam int PROG_W     = 16;
    localparam int PC_W       = 12;
    localparam int OP_W       = 4;
    localparam int BIT_SEL_W  = 3;
    localparam int NIB_W      = 4;
    localparam int ZF_BIT     = 2;
    localparam int FLAGS_W    = 8;
    localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
    localparam logic [DATA_W-1:0] TUB_RST  = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_B   = 8'h00;

    // operation codes presented by the decode stage
    typedef enum logic [OP_W-1:0] {
        OP_NONE         = 4'h0,
        OP_NIB_SWAP     = 4'h1,
        OP_NIB_TO_ACC   = 4'h2,
        OP_SKIP_NULL    = 4'h3,
        OP_COPY_SKIP    = 4'h4,
        OP_SKIP_BIT_CLR = 4'h5,
        OP_TBL_GIVEN    = 4'h6,
        OP_TBL_CURRENT  = 4'h7,
        OP_TBL_FINAL    = 4'h8,
        OP_XOR_ACC      = 4'h9,
        OP_XOR_MEM      = 4'ha,
        OP_XOR_IMM      = 4'hb
    } msxo_op_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_TBL   = 3'b010,
        ST_DUMMY = 3'b100
    } msxo_state_t;
endpackage

// [verilog/msxo_prog_rom.sv]
// program memory model read port: registered read word
`timescale 1ns/1ps
module msxo_prog_rom
    import msxo_pkg::*;
#(
    parameter int AW = PC_W,
    parameter int DW = PROG_W
) (
    // clock
    input  wire logic          clk,
    // write port for loading
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    // read port
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// [test/mcu_swap_skip_table_xor_ops_test.sv]
// self-checking bench for the swap, skip, table read and xor execution unit
`timescale 1ns/1ps
module mcu_swap_skip_table_xor_ops_test;
    import msxo_pkg::*;
    logic                  mclk      = 1'b0;
    logic                  rst       = 1'b1;
    logic                  op_valid  = 1'b0;
    logic [OP_W-1:0]       op_code   = 4'h0;
    logic [DATA_W-1:0]     mem_rdata = 8'h00;
    logic [DATA_W-1:0]     imm_data  = 8'h00;
    logic [BIT_SEL_W-1:0]  bit_sel   = 3'h0;
    logic [PC_W-1:0]       pc_now    = 12'h000;
    logic [DATA_W-1:0]     tp_lo     = 8'h00;
    logic [PC_W-DATA_W-1:0] tp_hi    = 4'h0;
    logic                  pw_en     = 1'b0;
    logic [PC_W-1:0]       pw_addr   = 12'h000;
    logic [PROG_W-1:0]     pw_data   = 16'h0000;
    logic [FLAGS_W-1:0]    flags_in  = 8'h00;
    logic                  mem_we, flags_we, dummy_insert, busy;
    logic [DATA_W-1:0]     mem_wdata, acc, tub;
    logic [FLAGS_W-1:0]    flags_out;
    logic [DATA_W-1:0]     acc_m     = ACC_RST;
    logic [DATA_W-1:0]     tub_m     = TUB_RST;
    logic [PROG_W-1:0]     w_tbl [3];
    int                    err_total = 0;
    int                    cmp_count = 0;

    always #2.5 mclk = ~mclk;

    msxo_exec DUT (
        .MCLK(mclk), .RST(rst), .OP_VALID(op_valid), .OP_CODE(op_code),
        .MEM_RDATA(mem_rdata), .IMM_DATA(imm_data), .BIT_SEL(bit_sel), .PC_NOW(pc_now),
        .TABLE_POINTER_LOWER(tp_lo), .TABLE_POINTER_UPPER(tp_hi),
        .PROG_WR_EN(pw_en), .PROG_WR_ADDR(pw_addr), .PROG_WR_DATA(pw_data),
        .FLAGS_IN(flags_in), .MEM_WE(mem_we), .MEM_WDATA(mem_wdata), .ACC(acc),
        .TABLE_UPPER_BYTE_REG(tub), .FLAGS_WE(flags_we), .FLAGS_OUT(flags_out),
        .DUMMY_INSERT(dummy_insert), .BUSY(busy)
    );

    function automatic logic [7:0] nib_x(input logic [7:0] v);
        return {v[3:0], v[7:4]};
    endfunction

    // only the zero bit may differ from the incoming status byte
    function automatic logic [7:0] flag_x(input logic [7:0] f, input logic [7:0] r);
        logic [7:0] o;
        o = f;
        o[ZF_BIT] = (r == ZERO_B);
        return o;
    endfunction

    task automatic finish_test;
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic load_word(input logic [11:0] a, input logic [15:0] d);
        @(posedge mclk);
        pw_en   <= 1'b1;
        pw_addr <= a;
        pw_data <= d;
        @(posedge mclk);
        pw_en   <= 1'b0;
    endtask

    // three pages kept distinct so a wrong page select returns a wrong word
    task automatic tbl_setup;
        logic [3:0] up;
        logic [7:0] lo;
        up = 4'($urandom_range(0, 13));
        lo = 8'($urandom);
        for (int k = 0; k < 3; k++) w_tbl[k] = 16'($urandom);
        @(posedge mclk);
        tp_hi  <= up;
        tp_lo  <= lo;
        pc_now <= {up + 4'h1, 8'($urandom)};
        load_word({up, lo}, w_tbl[0]);
        load_word({up + 4'h1, lo}, w_tbl[1]);
        load_word({4'hf, lo}, w_tbl[2]);
    endtask

    task automatic run_op(input logic [3:0] op, input logic [7:0] m, input logic [7:0] imm,
                          input logic [2:0] bs);
        logic [7:0]  e_acc, e_wd, res;
        logic        e_we, e_fwe, skip, tbl;
        logic [15:0] w;
        e_acc = acc_m;
        e_wd  = 8'h00;
        res   = 8'h00;
        e_we  = 1'b0;
        e_fwe = 1'b0;
        skip  = 1'b0;
        tbl   = (op >= 4'h6 && op <= 4'h8);
        w     = tbl ? w_tbl[op - 4'h6] : 16'h0000;
        case (op)
            4'h1: begin e_we = 1'b1; e_wd = nib_x(m); end
            4'h2: e_acc = nib_x(m);
            4'h3: skip = (m == 8'h00);
            4'h4: begin e_acc = m; skip = (m == 8'h00); end
            4'h5: skip = ~m[bs];
            4'h9: begin e_acc = acc_m ^ m; e_fwe = 1'b1; res = e_acc; end
            4'ha: begin e_we = 1'b1; e_wd = acc_m ^ m; e_fwe = 1'b1; res = e_wd; end
            4'hb: begin e_acc = acc_m ^ imm; e_fwe = 1'b1; res = e_acc; end
            default: ;
        endcase
        @(posedge mclk);
        op_valid  <= 1'b1;
        op_code   <= op;
        mem_rdata <= m;
        imm_data  <= imm;
        bit_sel   <= bs;
        flags_in  <= 8'($urandom);
        @(posedge mclk);
        op_valid  <= 1'b0;
        #1;
        chk(acc, e_acc, "acc");
        chk(mem_we, e_we, "mem write");
        if (e_we) chk(mem_wdata, e_wd, "mem data");
        chk(flags_we, e_fwe, "flag write");
        if (e_fwe) chk(flags_out, flag_x(flags_in, res), "flags");
        chk(busy, skip | tbl, "busy");
        acc_m = e_acc;
        @(posedge mclk);
        #1;
        chk(dummy_insert, skip, "dummy");
        chk(mem_we, tbl, "table write");
        if (tbl) chk(mem_wdata, w[7:0], "table low");
        if (tbl) tub_m = w[15:8];
        chk(tub, tub_m, "table high");
        chk(busy | flags_we, 1'b0, "second cycle");
    endtask

    initial begin
        repeat (60000) @(posedge mclk);
        err_total++;
        $display("BAD t=%0t run did not complete", $time);
        finish_test();
    end

    initial begin
        logic [3:0] op;
        logic [7:0] m;
        void'($urandom(32'hb148));
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        chk({acc, tub}, {ACC_RST, TUB_RST}, "reset regs");
        chk({mem_we, flags_we, dummy_insert, busy}, 4'h0, "reset strobes");
        $display("test reset done");
        // every op except OP_NONE with both extreme bytes
        for (int k = 1; k < 12; k++) begin
            if (k >= 6 && k <= 8) tbl_setup();
            run_op(4'(k), 8'h00, 8'h00, 3'h0);
            run_op(4'(k), 8'hff, 8'h5a, 3'h7);
        end
        for (int b = 0; b < 8; b++) begin
            run_op(4'h5, ~(8'h01 << b), 8'h00, 3'(b));
            run_op(4'h5, 8'h01 << b, 8'h00, 3'(b));
        end
        run_op(4'hb, 8'h00, acc_m, 3'h0);
        run_op(4'h9, acc_m, 8'h00, 3'h0);
        run_op(4'ha, acc_m, 8'h00, 3'h0);
        $display("test corners done");
        for (int n = 0; n < 400; n++) begin
            op = 4'($urandom_range(1, 11));
            m  = ($urandom_range(0, 3) == 0) ? 8'h00 : 8'($urandom);
            if (op >= 4'h6 && op <= 4'h8) tbl_setup();
            run_op(op, m, ($urandom_range(0, 7) == 0) ? acc_m : 8'($urandom),
                   3'($urandom));
        end
        $display("test random done");
        finish_test();
    end
endmodule
